// ### bench/cms_dev_model.sv
// Memory and port device model on the far side of the system bus
`timescale 1ns/1ps
module cms_dev_model #(
  parameter logic [7:0] MEM_BYTE = 8'h5a, // Byte a memory read returns
  parameter logic [7:0] IO_BYTE = 8'ha7 // Byte a port read returns
) (
  // Clock
  input wire logic sys_clk,
  // Address lines as the processor drives them
  input wire logic [15:0] cpu_addr,
  // Control bus
  input wire logic mem_read,
  input wire logic io_read,
  input wire logic mem_write,
  input wire logic io_write,
  // System data bus
  input wire logic sys_data_oe,
  input wire logic [7:0] sys_data_out,
  output logic [7:0] sys_data_in,
  output logic [7:0] last_wr
);
  logic [7:0] float_q = 8'h00; // Pattern shown while nobody drives
  // Bus level: the block, a selected device, or a changing float
  // Unselected devices stay off the bus
  // A port answers only when both address halves carry its code
  wire port_hit = (cpu_addr[15:8] == cpu_addr[7:0]);
  assign sys_data_in = sys_data_oe ? sys_data_out :
    mem_read ? MEM_BYTE : (io_read && port_hit) ? IO_BYTE : float_q;
  initial last_wr = 8'h00;
  // A stale value would hide a missing drive, so the float toggles
  always @(posedge sys_clk) begin
    float_q <= ~sys_data_in;
    // Store data while a write command stands
    if ((mem_write | io_write) && sys_data_oe) begin
      last_wr <= sys_data_out;
    end
  end
endmodule : cms_dev_model

// ### bench/tb_cms_sysctl.sv
// Self-checking bench for the processor module system control
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  fail_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
  $time, (a), (b)); end end
module tb_cms_sysctl;
  import cms_pkg::*;
  localparam logic [7:0] MEM_BYTE = 8'h5a;
  localparam logic [7:0] IO_BYTE = 8'ha7;
  // Stimulus and observed signals
  logic sys_clk = 1'b0, rst_n = 1'b0, cpu_sync = 1'b0;
  logic cpu_input_strobe = 1'b0, cpu_write_n = 1'b1;
  logic ready_in = 1'b0, hold_in = 1'b0, buffer_drive_allow = 1'b0;
  logic [7:0] cpu_data_in = 8'h00;
  logic [15:0] cpu_addr = 16'h0000; // Processor address lines
  logic [7:0] cpu_data_out, sys_data_in, sys_data_out, status, last_wr;
  logic cpu_data_oe, sys_data_oe, cpu_ready, cpu_hold;
  logic phase1, phase2, early_phase_one, status_latch_strobe_n;
  logic mem_read, mem_write, io_read, io_write, irq_grant;
  logic [4:0] cmd; // Commands in bench order
  int fail_count = 0, checks_done = 0, cyc = 0;
  assign cmd = {mem_read, mem_write, io_read, io_write, irq_grant};
  always #5 sys_clk = ~sys_clk;
  cms_sysctl cms_sysctl_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .cpu_sync(cpu_sync), .cpu_input_strobe(cpu_input_strobe),
    .cpu_write_n(cpu_write_n), .cpu_data_in(cpu_data_in),
    .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe),
    .ready_in(ready_in), .hold_in(hold_in), .cpu_ready(cpu_ready),
    .cpu_hold(cpu_hold), .phase1(phase1), .phase2(phase2),
    .early_phase_one(early_phase_one),
    .buffer_drive_allow(buffer_drive_allow), .sys_data_in(sys_data_in),
    .sys_data_out(sys_data_out), .sys_data_oe(sys_data_oe),
    .mem_read(mem_read), .mem_write(mem_write), .io_read(io_read),
    .io_write(io_write), .irq_grant(irq_grant),
    .status_latch_strobe_n(status_latch_strobe_n), .status(status));
  cms_dev_model #(.MEM_BYTE(MEM_BYTE), .IO_BYTE(IO_BYTE)) cms_dev_model_i (
    .sys_clk(sys_clk), .mem_read(mem_read), .io_read(io_read),
    .mem_write(mem_write), .io_write(io_write), .sys_data_oe(sys_data_oe),
    .sys_data_out(sys_data_out), .sys_data_in(sys_data_in),
    .cpu_addr(cpu_addr), .last_wr(last_wr));
  // Expected command group for a status byte and the strobes
  function automatic logic [4:0] exp_cmd(logic [7:0] s, logic rd);
    return {s[7] & rd, !rd & !s[4], s[6] & rd, !rd & s[4], s[0] & rd};
  endfunction : exp_cmd
  // Outputs read here are those registered at the previous edge
  task automatic step;
    @(posedge sys_clk);
  endtask : step
  task automatic wait_early(input logic lvl);
    int n;
    n = 0;
    step;
    while (early_phase_one !== lvl && n < 60) begin
      step;
      n++;
    end
  endtask : wait_early
  task automatic finish_test;
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // Two processor clock periods of phase counts
  task automatic clk_check;
    logic [7:0] c1, c2, ce, ov; // Unknown phases show up in these sums
    int n;
    logic p;
    c1 = 8'h00;
    c2 = 8'h00;
    ce = 8'h00;
    ov = 8'h00;
    n = 0;
    do begin
      p = phase1;
      step;
      n++;
    end while (!(phase1 === 1'b1 && p === 1'b0) && n < 100);
    repeat (100) begin
      c1 += phase1; c2 += phase2; ce += early_phase_one;
      ov += (phase1 & phase2);
      step;
    end
    `CHK(c1, 20)
    `CHK(c2, 50)
    `CHK(ce, 10)
    `CHK(ov, 0)
    `CHK(phase1, 1'b1)
  endtask : clk_check
  // One machine cycle: status, then a read or write with w waits
  task automatic run_cycle(input logic [7:0] s, input logic rd,
                           input logic al, input int w);
    logic r, h;
    logic [7:0] p;
    logic [4:0] e;
    r = 1'($urandom);
    h = 1'($urandom);
    p = 8'($urandom);
    e = exp_cmd(s, rd);
    ready_in <= r;
    hold_in <= h;
    buffer_drive_allow <= al;
    wait_early(1'b1);
    cpu_sync <= 1'b1;
    cpu_data_in <= s;
    step;
    step;
    `CHK(status_latch_strobe_n, 1'b0)
    wait_early(1'b0);
    cpu_sync <= 1'b0;
    repeat (3) step;
    cpu_data_in <= ~s;
    cpu_addr <= {p, p};
    step;
    step;
    `CHK(status, s)
    `CHK(status_latch_strobe_n, 1'b1)
    `CHK(cpu_ready, r)
    `CHK(cpu_hold, h)
    if (rd) cpu_input_strobe <= 1'b1;
    else cpu_write_n <= 1'b0;
    step;
    step;
    // Wait states only stretch the command
    repeat (w + 1) begin
      `CHK(cmd, e)
      `CHK(cpu_data_oe, al & rd)
      `CHK(sys_data_oe, al & !rd)
      `CHK(sys_data_out, ~s)
      step;
    end
    if (rd && (s[7] | s[6])) begin
      `CHK(cpu_data_out, s[7] ? MEM_BYTE : IO_BYTE)
    end
    if (!rd && al) begin
      `CHK(last_wr, ~s)
    end
    cpu_input_strobe <= 1'b0;
    cpu_write_n <= 1'b1;
    step;
    step;
    `CHK(cmd, 5'h00)
    `CHK(status, s)
  endtask : run_cycle
  // Cycle ceiling well above the planned run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      finish_test;
    end
  end
  // Corner cases first: each command alone, one with the buffer off
  logic [7:0] cs [5] = '{8'h80, 8'h40, 8'h01, 8'h00, 8'h10};
  logic cr [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic ca [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  initial begin
    void'($urandom(32'he3742807));
    repeat (4) step;
    `CHK({cmd, cpu_data_oe, sys_data_oe}, 7'h00)
    `CHK({phase1, phase2, early_phase_one}, 3'h0)
    `CHK({status_latch_strobe_n, status}, 9'h100)
    step;
    rst_n <= 1'b1;
    step;
    // No command before a status byte has been taken
    cpu_input_strobe <= 1'b1;
    cpu_write_n <= 1'b0;
    repeat (3) step;
    `CHK(cmd, 5'h00)
    cpu_input_strobe <= 1'b0;
    cpu_write_n <= 1'b1;
    clk_check;
    for (int i = 0; i < 5; i++) run_cycle(cs[i], cr[i], ca[i], i % 3);
    // Reset in mid-run drops the held status and blocks commands
    rst_n <= 1'b0;
    repeat (2) step;
    rst_n <= 1'b1;
    cpu_write_n <= 1'b0;
    repeat (3) step;
    `CHK({status_latch_strobe_n, status}, 9'h100)
    `CHK(cmd, 5'h00)
    cpu_write_n <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      run_cycle(8'($urandom), 1'($urandom), ($urandom % 4) != 0,
                $urandom % 4);
    end
    finish_test;
  end
endmodule : tb_cms_sysctl

// ### rtl/cms_clkgen.sv
// Two-phase processor clock generator from a presettable counter
`timescale 1ns/1ps
module cms_clkgen
  import cms_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Phase outputs
  output logic phase1,
  output logic phase2,
  output logic early_phase_one
);
  logic [2:0] pre_q, pre_d;  // Source prescaler
  logic [3:0] cnt_q, cnt_d;  // Phase counter
  logic phase1_q, phase2_q, early_q;
  wire tick = (pre_q == PRE_LAST); // One source period elapsed

  // Inclusive span decode
  function automatic logic in_span(input logic [3:0] v,
                                   input logic [3:0] lo,
                                   input logic [3:0] hi);
    in_span = (v >= lo) && (v <= hi);
  endfunction : in_span

  // Prescaler models the source rate on the system clock
  assign pre_d = tick ? 3'h0 : 3'(pre_q + 3'h1);
  // Counter steps per source tick and reloads at the end
  assign cnt_d = !tick ? cnt_q :
                 (cnt_q == CLK_LAST) ? CLK_PRESET : 4'(cnt_q + 4'h1);

  // Counter registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pre_q <= 3'h0;
      cnt_q <= CLK_PRESET;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
    end
  end

  // Decoded phases registered so outputs are glitch free
  // Early phase one leads phase one by a source period
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase1_q <= 1'b0;
      phase2_q <= 1'b0;
      early_q <= 1'b0;
    end else begin
      phase1_q <= in_span(cnt_q, P1_FIRST, P1_LAST);
      phase2_q <= in_span(cnt_q, P2_FIRST, P2_LAST);
      early_q <= in_span(cnt_q, EARLY_CNT, EARLY_CNT);
    end
  end

  assign phase1 = phase1_q;
  assign phase2 = phase2_q;
  assign early_phase_one = early_q;

  // Counter reloads the preset after its last count
  property p_reload;
    @(posedge sys_clk) disable iff (!rst_n)
      (tick && cnt_q == CLK_LAST) |=> (cnt_q == CLK_PRESET);
  endproperty
  a_reload: assert property (p_reload)
    else $error("counter did not reload preset");

  // Phases never active together
  property p_no_overlap;
    @(posedge sys_clk) disable iff (!rst_n)
      !(phase1_q && phase2_q);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("clock phases overlap");

  // Early phase one is followed directly by phase one
  property p_early_lead;
    @(posedge sys_clk) disable iff (!rst_n)
      $fell(early_q) |-> phase1_q;
  endproperty
  a_early_lead: assert property (p_early_lead)
    else $error("early phase not ahead of phase one");
endmodule : cms_clkgen

// ### rtl/cms_pkg.sv
// Shared constants and types for the processor module system control
package cms_pkg;
  // Clock rates
  localparam int unsigned SYS_HZ = 100_000_000; // System clock rate
  localparam int unsigned SRC_HZ = 20_000_000;  // Phase source rate
  localparam int unsigned SRC_DIV_I = SYS_HZ / SRC_HZ;
  localparam logic [2:0] SRC_DIV = 3'(SRC_DIV_I); // Cycles per source tick
  localparam logic [2:0] PRE_LAST = 3'(SRC_DIV_I - 1);

  // Phase counter preset and decode points (4-bit counter)
  localparam logic [3:0] CLK_PRESET = 4'h6; // Reload value
  localparam logic [3:0] CLK_LAST = 4'hf;   // Last count before reload
  localparam logic [3:0] P1_FIRST = 4'h6;   // Phase one active span
  localparam logic [3:0] P1_LAST = 4'h7;
  localparam logic [3:0] P2_FIRST = 4'h9;   // Phase two active span
  localparam logic [3:0] P2_LAST = 4'hd;
  localparam logic [3:0] EARLY_CNT = 4'hf;  // Advanced phase one count

  // Status byte, one flag per bit, msb first
  typedef struct packed {
    logic memr;  // Memory read cycle
    logic inp;   // Input cycle
    logic m1;    // Opcode fetch
    logic out;   // Output cycle
    logic hlta;  // Halt acknowledge
    logic stack; // Stack access
    logic wo_n;  // Write or output, active low
    logic irq_ack; // Interrupt acknowledge
  } cms_status_t;

  localparam cms_status_t STATUS_RST = 8'h00;

  // Decoded command group
  typedef struct packed {
    logic mem_rd;
    logic mem_wr;
    logic io_rd;
    logic io_wr;
    logic irq;
  } cms_cmd_t;

  localparam cms_cmd_t CMD_IDLE = 5'h00;

  // Machine cycle tracking
  typedef enum logic [1:0] {
    CYC_IDLE,   // No status seen since reset
    CYC_STATUS, // Status strobe in progress
    CYC_HELD    // Status held, commands allowed
  } cms_cyc_t;
endpackage : cms_pkg

// ### rtl/cms_sysctl.sv
// Processor module system control: clocks, status latch, bus control
`timescale 1ns/1ps
// Function
// - Status, address, data, then repeat
// - Counter from 20 MHz source makes phases
// - Two clock phases never overlap
// - Decode advanced phase one for synchronisers
// - Strobe is cycle marker gated by early phase
// - Eight-bit latch captures status, then holds
// - Latch taps processor side before buffer
// - Status plus strobes give five commands
// - Buffer direction follows processor input strobe
// - Drive allow low floats the buffer
// - Eight-bit shared bus; unselected outputs float
// - Grant from latched status and input strobe
// - Ready low in T2 inserts wait states
module cms_sysctl
  import cms_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Processor control inputs
  input wire logic cpu_sync,
  input wire logic cpu_input_strobe,
  input wire logic cpu_write_n,
  // Processor data lines
  input wire logic [7:0] cpu_data_in,
  output logic [7:0] cpu_data_out,
  output logic cpu_data_oe,
  // External requests and their synchronised copies
  input wire logic ready_in,
  input wire logic hold_in,
  output logic cpu_ready,
  output logic cpu_hold,
  // Processor clock phases
  output logic phase1,
  output logic phase2,
  output logic early_phase_one,
  // System data bus
  input wire logic buffer_drive_allow,
  input wire logic [7:0] sys_data_in,
  output logic [7:0] sys_data_out,
  output logic sys_data_oe,
  // Control bus
  output logic mem_read,
  output logic mem_write,
  output logic io_read,
  output logic io_write,
  output logic irq_grant,
  output logic status_latch_strobe_n,
  output logic [7:0] status
);

  // Clock generator outputs
  logic ph1_w; // Phase one
  logic ph2_w; // Phase two
  logic early_w; // Advanced phase one

  // Status latch and strobe
  cms_status_t status_q, status_d; // Latched status byte
  logic strobe_q; // Strobe active, active high internally
  logic early_prev_q; // Previous early phase, for edge detect

  // Cycle tracking
  cms_cyc_t cyc_q, cyc_d;

  // Commands
  cms_cmd_t cmd_q, cmd_d;

  // Synchronised requests
  logic ready_q, hold_q;

  // Buffer path registers
  logic [7:0] cpu_dout_q, sys_dout_q;
  logic cpu_oe_q, sys_oe_q;

  // Phase generation lives in its own module
  cms_clkgen cms_clkgen_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .phase1(ph1_w),
    .phase2(ph2_w),
    .early_phase_one(early_w)
  );

  // Strobe wants the cycle marker and early phase together
  wire strobe_now = cpu_sync && early_w;
  // Rising edge of early phase samples external requests
  wire early_rise = early_w && !early_prev_q;

  // Latch is transparent during strobe, holds otherwise
  // Taps processor-side data so buffer release cannot upset it
  assign status_d = strobe_q ? cms_status_t'(cpu_data_in) : status_q;

  // Cycle state: no command until a status has been latched
  always_comb begin
    cyc_d = cyc_q;
    case (cyc_q)
      // Wait for the first status strobe after reset
      CYC_IDLE: begin
        if (strobe_q) begin
          cyc_d = CYC_STATUS;
        end
      end
      // Strobe in progress; commands held off
      CYC_STATUS: begin
        if (!strobe_q) begin
          cyc_d = CYC_HELD;
        end
      end
      // Status stable; a new strobe starts the next cycle
      CYC_HELD: begin
        if (strobe_q) begin
          cyc_d = CYC_STATUS;
        end
      end
      default: begin
        cyc_d = CYC_IDLE;
      end
    endcase
  end

  // Commands allowed only while a status is held
  wire cmd_ok = (cyc_q == CYC_HELD);
  // Write strobe from the processor, active high
  wire wr_act = !cpu_write_n;

  // Command decode from latched status and strobes
  assign cmd_d.mem_rd = cmd_ok && status_q.memr && cpu_input_strobe;
  assign cmd_d.io_rd = cmd_ok && status_q.inp && cpu_input_strobe;
  assign cmd_d.mem_wr = cmd_ok && wr_act && !status_q.out;
  assign cmd_d.io_wr = cmd_ok && wr_act && status_q.out;
  // Grant enables the restart port onto the bus
  assign cmd_d.irq = cmd_ok && status_q.irq_ack && cpu_input_strobe;

  // Buffer direction from the input strobe
  // Drive allow low floats both sides for DMA
  wire cpu_oe_d = buffer_drive_allow && cpu_input_strobe;
  wire sys_oe_d = buffer_drive_allow && !cpu_input_strobe;

  // Strobe and latch registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      strobe_q <= 1'b0;
      early_prev_q <= 1'b0;
      status_q <= STATUS_RST;
    end else begin
      strobe_q <= strobe_now;
      early_prev_q <= early_w;
      status_q <= status_d;
    end
  end

  // Cycle state register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cyc_q <= CYC_IDLE;
    end else begin
      cyc_q <= cyc_d;
    end
  end

  // Command register; a wait state simply keeps the command up
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmd_q <= CMD_IDLE;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  // Requests sampled on early phase edge, as a D flip-flop would
  // Ready held low makes the processor stretch T2
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
      hold_q <= 1'b0;
    end else if (early_rise) begin
      ready_q <= ready_in;
      hold_q <= hold_in;
    end
  end

  // Buffer data and enables; one cycle latency both ways
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cpu_dout_q <= 8'h00;
      sys_dout_q <= 8'h00;
      cpu_oe_q <= 1'b0;
      sys_oe_q <= 1'b0;
    end else begin
      cpu_dout_q <= sys_data_in;
      sys_dout_q <= cpu_data_in;
      cpu_oe_q <= cpu_oe_d;
      sys_oe_q <= sys_oe_d;
    end
  end

  // Output connections, all from flip-flops
  assign phase1 = ph1_w;
  assign phase2 = ph2_w;
  assign early_phase_one = early_w;
  assign status_latch_strobe_n = !strobe_q;
  assign status = status_q;
  assign mem_read = cmd_q.mem_rd;
  assign mem_write = cmd_q.mem_wr;
  assign io_read = cmd_q.io_rd;
  assign io_write = cmd_q.io_wr;
  assign irq_grant = cmd_q.irq;
  assign cpu_ready = ready_q;
  assign cpu_hold = hold_q;
  assign cpu_data_out = cpu_dout_q;
  assign cpu_data_oe = cpu_oe_q;
  assign sys_data_out = sys_dout_q;
  assign sys_data_oe = sys_oe_q;

  // Any command on the control bus
  wire any_cmd = cmd_q.mem_rd || cmd_q.mem_wr || cmd_q.io_rd ||
                 cmd_q.io_wr || cmd_q.irq;

  // Commands only after status was latched
  property p_order;
    @(posedge sys_clk) disable iff (!rst_n)
      any_cmd |-> $past(cyc_q) == CYC_HELD;
  endproperty
  a_order: assert property (p_order)
    else $error("command before status latched");

  // Strobe only from marker and early phase
  property p_strobe;
    @(posedge sys_clk) disable iff (!rst_n)
      !status_latch_strobe_n |-> $past(cpu_sync && early_w);
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("strobe without marker and early phase");

  // Latch takes the data seen during strobe
  property p_capture;
    @(posedge sys_clk) disable iff (!rst_n)
      strobe_q |=> status_q == $past(cpu_data_in);
  endproperty
  a_capture: assert property (p_capture)
    else $error("status not captured");

  // Latch holds outside strobe, even when the buffer is released
  property p_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      !strobe_q |=> $stable(status_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("status changed outside strobe");

  // Read commands require the input strobe a cycle earlier
  property p_read_cmd;
    @(posedge sys_clk) disable iff (!rst_n)
      (cmd_q.mem_rd || cmd_q.io_rd) |-> $past(cpu_input_strobe);
  endproperty
  a_read_cmd: assert property (p_read_cmd)
    else $error("read command without input strobe");

  // Write commands split on the output status bit
  property p_write_cmd;
    @(posedge sys_clk) disable iff (!rst_n)
      cmd_q.io_wr |-> !cmd_q.mem_wr && $past(status_q.out && wr_act);
  endproperty
  a_write_cmd: assert property (p_write_cmd)
    else $error("bad write command decode");

  // Buffer never drives both ways
  property p_direction;
    @(posedge sys_clk) disable iff (!rst_n)
      cpu_oe_q |-> !sys_oe_q && $past(cpu_input_strobe);
  endproperty
  a_direction: assert property (p_direction)
    else $error("buffer direction wrong");

  // System side drives only with allow and no input strobe
  property p_sys_dir;
    @(posedge sys_clk) disable iff (!rst_n)
      sys_oe_q |-> !cpu_oe_q &&
        $past(buffer_drive_allow && !cpu_input_strobe);
  endproperty
  a_sys_dir: assert property (p_sys_dir)
    else $error("system side driven without allow");

  // Drive allow low floats the buffer next cycle
  property p_release;
    @(posedge sys_clk) disable iff (!rst_n)
      !buffer_drive_allow |=> !cpu_oe_q && !sys_oe_q;
  endproperty
  a_release: assert property (p_release)
    else $error("buffer driven without allow");

  // Grant comes from interrupt status and input strobe
  property p_grant;
    @(posedge sys_clk) disable iff (!rst_n)
      cmd_q.irq |-> $past(status_q.irq_ack && cpu_input_strobe);
  endproperty
  a_grant: assert property (p_grant)
    else $error("grant without interrupt status");

  // Ready copy changes only on an early phase edge
  property p_ready;
    @(posedge sys_clk) disable iff (!rst_n)
      !$stable(ready_q) |-> $past(early_rise);
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready sampled off early phase");
endmodule : cms_sysctl
